// >>> pll_pkg.sv
package pll_pkg;
	// ------------------------------------------------------------
	// serial word layout, first bit shifted is the top bit
	// ------------------------------------------------------------
	localparam int WORD_BITS = 23;
	localparam int MAIN_BITS = 11;
	localparam int SWL_BITS  = 7;
	localparam int POS_SEL   = 0;
	localparam int POS_FILL  = 1;
	localparam int POS_REF   = 2;
	localparam int POS_MON   = 3;
	localparam int POS_POL   = 4;
	localparam int POS_SWL   = 5;
	localparam int POS_MAIN  = 12;
	localparam int SEC_RX    = 0;
	localparam int SEC_TX    = 1;

	typedef struct packed {
		logic [MAIN_BITS-1:0] main_count_bits;
		logic [SWL_BITS-1:0]  swallow_count_bits;
		logic                 phase_polarity_bit;
	} sec_cfg_t;

	localparam logic [WORD_BITS-1:0] WORD_RST = 23'h00_0000;
	localparam sec_cfg_t             CFG_RST  = 19'h0_0000;
	localparam logic                 REF_RST  = 1'b0;
	localparam logic                 MON_RST  = 1'b0;

	// ------------------------------------------------------------
	// dividers
	// ------------------------------------------------------------
	localparam logic [6:0] PRE_LOW       = 7'h40;
	localparam logic [6:0] PRE_HIGH      = 7'h41;
	localparam logic [9:0] REF_DIV_SHORT = 10'h1ff;
	localparam logic [9:0] REF_DIV_LONG  = 10'h3ff;

	// ------------------------------------------------------------
	// timing at 40 MHz
	// ------------------------------------------------------------
	localparam int CLK_PS       = 25000;
	localparam int LOCK_WIN_NS  = 625;
	localparam int LOCK_WIN_CYC = (LOCK_WIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int LOCK_RUNS    = 3;
	localparam int SHIFT_HALF_NS  = 100;
	localparam int SHIFT_HALF_CYC =
		(SHIFT_HALF_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int LOAD_HIGH_NS  = 200;
	localparam int LOAD_HIGH_CYC =
		(LOAD_HIGH_NS * 1000 + CLK_PS - 1) / CLK_PS;

	// ------------------------------------------------------------
	// host register port
	// ------------------------------------------------------------
	localparam int         ADDR_W   = 8;
	localparam logic [7:0] REG_WORD = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam int         STAT_BUSY = 0;
	localparam int         STAT_DONE = 1;
endpackage

// >>> synth_link_if.sv
`timescale 1ns/1ps
interface synth_link_if;
	logic ser_data;
	logic shift_clk;
	logic latch_load_strobe;

	modport device (
		input ser_data,
		input shift_clk,
		input latch_load_strobe
	);
	modport host (
		output ser_data,
		output shift_clk,
		output latch_load_strobe
	);
endinterface

// >>> lock_watch.sv
`timescale 1ns/1ps
module lock_watch #(
	parameter int WIN_CYC = pll_pkg::LOCK_WIN_CYC,
	parameter int RUNS    = pll_pkg::LOCK_RUNS
) (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic phase_err,
	output logic      locked
);
	import pll_pkg::*;

	typedef struct packed {
		logic       err_d;
		logic [7:0] width;
		logic [1:0] good;
		logic       locked;
	} lw_st_t;

	lw_st_t s_r;
	lw_st_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.err_d = phase_err;
		if (phase_err) begin
			if (s_r.width != 8'hff)
				s_nxt.width = s_r.width + 8'h01;
			// a long error drops lock at once, not at its end
			if (s_r.width >= 8'(WIN_CYC - 1)) begin
				s_nxt.locked = 1'b0;
				s_nxt.good   = 2'h0;
			end
		end else if (s_r.err_d) begin
			s_nxt.width = 8'h00;
			if (s_r.width < 8'(WIN_CYC)) begin
				if (s_r.good != 2'h3)
					s_nxt.good = s_r.good + 2'h1;
				if (s_r.good >= 2'(RUNS - 1))
					s_nxt.locked = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign locked = s_r.locked;
endmodule

// >>> synth_device.sv
`timescale 1ns/1ps
module synth_device #(
	parameter int WIN_CYC = pll_pkg::LOCK_WIN_CYC
) (
	input  wire logic   mclk,
	input  wire logic   rst_n,
	synth_link_if.device link,
	input  wire logic   crystal_clock_in,
	input  wire logic   tx_vco_input,
	input  wire logic   rx_vco_input,
	input  wire logic   tx_supply_on,
	input  wire logic   rx_supply_on,
	output logic        reference_monitor_out,
	output logic        divider_monitor_out,
	output logic        tx_lock_flag,
	output logic        rx_lock_flag,
	output logic        tx_pump_out,
	output logic        tx_pump_oe_n,
	output logic        rx_pump_out,
	output logic        rx_pump_oe_n,
	output logic        tx_switched_filter_out,
	output logic        tx_switched_filter_oe_n,
	output logic        rx_switched_filter_out,
	output logic        rx_switched_filter_oe_n
);
	import pll_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0]           vco_s;
		logic [6:0]           pre;
		logic [SWL_BITS-1:0]  swl;
		logic [MAIN_BITS-1:0] main;
		logic                 fdiv;
		logic                 up;
		logic                 dn;
		logic                 drv;
		logic                 val;
	} sec_run_t;

	typedef struct packed {
		logic [WORD_BITS-1:0] shift;
		logic                 sclk_d;
		sec_cfg_t [1:0]       cfg;
		logic                 ref_sel;
		logic                 mon_sel;
		logic [1:0]           tx_pwr_s;
		logic [1:0]           rx_pwr_s;
		logic [2:0]           xtal_s;
		logic [9:0]           ref_cnt;
		logic                 fr;
		logic                 fp_mon;
		sec_run_t [1:0]       run;
	} dev_st_t;

	dev_st_t    s_r;
	dev_st_t    s_nxt;
	logic [1:0] vco_in;
	logic [1:0] lock;
	logic [1:0] sw_on;

	assign vco_in = {tx_vco_input, rx_vco_input};

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic [WORD_BITS-1:0] w;
		logic [9:0]           ref_last;
		logic [6:0]           pre_last;
		sec_cfg_t             ld;
		w        = s_r.shift;
		ref_last = REF_DIV_LONG;
		pre_last = PRE_LOW - 7'h01;
		ld       = CFG_RST;
		s_nxt    = s_r;

		// serial side: the host runs on mclk, so no synchroniser
		s_nxt.sclk_d = link.shift_clk;
		if (link.shift_clk && !s_r.sclk_d)
			s_nxt.shift = {s_r.shift[WORD_BITS-2:0],
				link.ser_data};

		// level copy: shifting during the strobe reaches the latch
		if (link.latch_load_strobe) begin
			ld.main_count_bits    = w[POS_MAIN +: MAIN_BITS];
			ld.swallow_count_bits = w[POS_SWL +: SWL_BITS];
			ld.phase_polarity_bit = w[POS_POL];
			if (w[POS_SEL])
				s_nxt.cfg[SEC_TX] = ld;
			else
				s_nxt.cfg[SEC_RX] = ld;
			s_nxt.ref_sel = w[POS_REF];
			s_nxt.mon_sel = w[POS_MON];
		end

		// supply domains
		s_nxt.tx_pwr_s = {s_r.tx_pwr_s[0], tx_supply_on};
		s_nxt.rx_pwr_s = {s_r.rx_pwr_s[0], rx_supply_on};
		if (!s_r.tx_pwr_s[1])
			s_nxt.cfg[SEC_TX] = CFG_RST;
		if (!s_r.rx_pwr_s[1]) begin
			s_nxt.cfg[SEC_RX] = CFG_RST;
			s_nxt.ref_sel     = REF_RST;
		end

		// shared reference counter on crystal edges
		s_nxt.xtal_s = {s_r.xtal_s[1:0], crystal_clock_in};
		s_nxt.fr     = 1'b0;
		if (s_r.ref_sel)
			ref_last = REF_DIV_SHORT;
		if (s_r.xtal_s[1] && !s_r.xtal_s[2]) begin
			// >= so a shorter ratio loaded mid-count wraps at once
			if (s_r.ref_cnt >= ref_last) begin
				s_nxt.ref_cnt = 10'h000;
				s_nxt.fr      = 1'b1;
			end else begin
				s_nxt.ref_cnt = s_r.ref_cnt + 10'h001;
			end
		end

		s_nxt.fp_mon = s_r.mon_sel ? s_r.run[SEC_TX].fdiv
			: s_r.run[SEC_RX].fdiv;

		// per-section pulse swallow divider and phase detector
		for (int i = 0; i < 2; i++) begin
			s_nxt.run[i].vco_s = {s_r.run[i].vco_s[1:0], vco_in[i]};
			s_nxt.run[i].fdiv  = 1'b0;
			pre_last = (s_r.run[i].swl != '0) ? PRE_HIGH - 7'h01
				: PRE_LOW - 7'h01;
			if (s_r.run[i].vco_s[1] && !s_r.run[i].vco_s[2]) begin
				if (s_r.run[i].pre >= pre_last) begin
					s_nxt.run[i].pre = 7'h00;
					if (s_r.run[i].swl != '0)
						s_nxt.run[i].swl = s_r.run[i].swl - 7'h01;
					// main count below 16 is not supported
					if (s_r.run[i].main <= 11'h001) begin
						s_nxt.run[i].main =
							s_r.cfg[i].main_count_bits;
						s_nxt.run[i].swl =
							s_r.cfg[i].swallow_count_bits;
						s_nxt.run[i].fdiv = 1'b1;
					end else begin
						s_nxt.run[i].main = s_r.run[i].main - 11'h001;
					end
				end else begin
					s_nxt.run[i].pre = s_r.run[i].pre + 7'h01;
				end
			end

			// up: reference came first; dn: divided came first
			s_nxt.run[i].up = s_r.run[i].up | s_r.fr;
			s_nxt.run[i].dn = s_r.run[i].dn | s_r.run[i].fdiv;
			if (s_nxt.run[i].up && s_nxt.run[i].dn) begin
				s_nxt.run[i].up = 1'b0;
				s_nxt.run[i].dn = 1'b0;
			end
			s_nxt.run[i].drv = s_r.run[i].up ^ s_r.run[i].dn;
			s_nxt.run[i].val = s_r.run[i].up
				? s_r.cfg[i].phase_polarity_bit
				: ~s_r.cfg[i].phase_polarity_bit;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s_r         <= '0;
			s_r.shift   <= WORD_RST;
			s_r.cfg     <= {CFG_RST, CFG_RST};
			s_r.ref_sel <= REF_RST;
			s_r.mon_sel <= MON_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------
	// lock watch and switches per section
	// ------------------------------------------------------------
	for (genvar g = 0; g < 2; g++) begin : g_sec
		lock_watch #(
			.WIN_CYC (WIN_CYC),
			.RUNS    (LOCK_RUNS)
		) u_lock (
			.mclk      (mclk),
			.rst_n     (rst_n),
			.phase_err (s_r.run[g].up | s_r.run[g].dn),
			.locked    (lock[g])
		);
		// the select bit in the shift register picks the switch
		assign sw_on[g] = link.latch_load_strobe
			&& (s_r.shift[POS_SEL] == (g == SEC_TX));
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign reference_monitor_out = s_r.fr;
	assign divider_monitor_out   = s_r.fp_mon;
	assign tx_lock_flag          = lock[SEC_TX];
	assign rx_lock_flag          = lock[SEC_RX];
	assign tx_pump_out           = s_r.run[SEC_TX].val;
	assign tx_pump_oe_n          = ~s_r.run[SEC_TX].drv;
	assign rx_pump_out           = s_r.run[SEC_RX].val;
	assign rx_pump_oe_n          = ~s_r.run[SEC_RX].drv;
	assign tx_switched_filter_out  = s_r.run[SEC_TX].val;
	assign tx_switched_filter_oe_n =
		~(sw_on[SEC_TX] & s_r.run[SEC_TX].drv);
	assign rx_switched_filter_out  = s_r.run[SEC_RX].val;
	assign rx_switched_filter_oe_n =
		~(sw_on[SEC_RX] & s_r.run[SEC_RX].drv);
endmodule

// >>> serial_host.sv
`timescale 1ns/1ps
module serial_host #(
	parameter int HALF_CYC = pll_pkg::SHIFT_HALF_CYC,
	parameter int LOAD_CYC = pll_pkg::LOAD_HIGH_CYC
) (
	input  wire logic                       mclk,
	input  wire logic                       rst_n,
	synth_link_if.host                      link,
	input  wire logic [pll_pkg::ADDR_W-1:0] addr,
	input  wire logic [31:0]                wdata,
	input  wire logic                       wr,
	input  wire logic                       rd,
	output logic [31:0]                     rdata
);
	import pll_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_LOW,
		ST_HIGH,
		ST_LOAD
	} host_st_t;

	typedef struct packed {
		host_st_t             st;
		logic [WORD_BITS-1:0] word;
		logic [4:0]           bit_idx;
		logic [7:0]           tmr;
		logic                 sdata;
		logic                 sclk;
		logic                 le;
		logic                 done;
		logic [31:0]          rdata;
	} host_t;

	host_t s_r;
	host_t s_nxt;

	// ------------------------------------------------------------
	// register port and shift sequence
	// ------------------------------------------------------------
	always_comb begin
		s_nxt       = s_r;
		s_nxt.rdata = 32'h0000_0000;
		if (rd) begin
			if (addr == REG_WORD)
				s_nxt.rdata[WORD_BITS-1:0] = s_r.word;
			else if (addr == REG_STAT) begin
				s_nxt.rdata[STAT_BUSY] = (s_r.st != ST_IDLE);
				s_nxt.rdata[STAT_DONE] = s_r.done;
				s_nxt.done = 1'b0;
			end
		end

		unique case (s_r.st)
			ST_IDLE: begin
				// a word written while busy is dropped
				if (wr && addr == REG_WORD) begin
					s_nxt.word    = wdata[WORD_BITS-1:0];
					s_nxt.sdata   = wdata[WORD_BITS-1];
					s_nxt.bit_idx = 5'(WORD_BITS - 1);
					s_nxt.tmr     = 8'(HALF_CYC - 1);
					s_nxt.st      = ST_LOW;
				end
			end
			ST_LOW: begin
				if (s_r.tmr == 8'h00) begin
					s_nxt.sclk = 1'b1;
					s_nxt.tmr  = 8'(HALF_CYC - 1);
					s_nxt.st   = ST_HIGH;
				end else begin
					s_nxt.tmr = s_r.tmr - 8'h01;
				end
			end
			ST_HIGH: begin
				if (s_r.tmr == 8'h00) begin
					s_nxt.sclk = 1'b0;
					s_nxt.tmr  = 8'(HALF_CYC - 1);
					if (s_r.bit_idx == 5'h00) begin
						s_nxt.le  = 1'b1;
						s_nxt.tmr = 8'(LOAD_CYC - 1);
						s_nxt.st  = ST_LOAD;
					end else begin
						// data changes only on the falling edge
						s_nxt.bit_idx = s_r.bit_idx - 5'h01;
						s_nxt.sdata = s_r.word[s_r.bit_idx - 5'h01];
						s_nxt.st = ST_LOW;
					end
				end else begin
					s_nxt.tmr = s_r.tmr - 8'h01;
				end
			end
			ST_LOAD: begin
				if (s_r.tmr == 8'h00) begin
					s_nxt.le   = 1'b0;
					s_nxt.done = 1'b1; // set wins over read clear
					s_nxt.st   = ST_IDLE;
				end else begin
					s_nxt.tmr = s_r.tmr - 8'h01;
				end
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s_r    <= '0;
			s_r.st <= ST_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign link.ser_data          = s_r.sdata;
	assign link.shift_clk         = s_r.sclk;
	assign link.latch_load_strobe = s_r.le;
	assign rdata                  = s_r.rdata;
endmodule

// >>> synth_link_asserts.sv
`timescale 1ns/1ps
module synth_link_asserts (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ser_data,
	input wire logic shift_clk,
	input wire logic latch_load_strobe,
	input wire logic reference_monitor_out,
	input wire logic tx_pump_out,
	input wire logic tx_pump_oe_n,
	input wire logic rx_pump_out,
	input wire logic rx_pump_oe_n,
	input wire logic tx_switched_filter_out,
	input wire logic tx_switched_filter_oe_n,
	input wire logic rx_switched_filter_out,
	input wire logic rx_switched_filter_oe_n
);
	// ------------------------------------------------------------
	// shift clock rises since the last load strobe
	// ------------------------------------------------------------
	logic [4:0] rises_r;
	logic [4:0] rises_nxt;
	logic       sclk_d_r;

	always_comb begin
		rises_nxt = rises_r;
		if (latch_load_strobe)
			rises_nxt = 5'h0;
		else if (shift_clk && !sclk_d_r)
			rises_nxt = rises_r + 5'h1;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rises_r  <= 5'h0;
			sclk_d_r <= 1'b0;
		end else begin
			rises_r  <= rises_nxt;
			sclk_d_r <= shift_clk;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	word_length_a: assert property (
		$rose(latch_load_strobe) |-> rises_r == 5'h17)
		else $error("load strobe raised without a full word");
	strobe_width_a: assert property (
		$rose(latch_load_strobe) |-> latch_load_strobe [*8] ##1
			!latch_load_strobe)
		else $error("load strobe width wrong");
	no_shift_load_a: assert property (
		latch_load_strobe |-> !$rose(shift_clk))
		else $error("shift clock rose during load strobe");
	data_setup_a: assert property (
		$rose(shift_clk) |-> $stable(ser_data))
		else $error("serial data changed at shift edge");
	tx_switch_gate_a: assert property (
		!tx_switched_filter_oe_n |-> latch_load_strobe)
		else $error("transmit switch closed without strobe");
	rx_switch_gate_a: assert property (
		!rx_switched_filter_oe_n |-> latch_load_strobe)
		else $error("reception switch closed without strobe");
	one_switch_a: assert property (
		!(!tx_switched_filter_oe_n && !rx_switched_filter_oe_n))
		else $error("both switches closed");
	switch_level_a: assert property (
		!tx_switched_filter_oe_n |-> !tx_pump_oe_n &&
			tx_switched_filter_out == tx_pump_out)
		else $error("switch output differs from pump");
	rx_switch_level_a: assert property (
		!rx_switched_filter_oe_n |-> !rx_pump_oe_n &&
			rx_switched_filter_out == rx_pump_out)
		else $error("reception switch output differs from pump");
	ref_pulse_a: assert property (
		reference_monitor_out |=> !reference_monitor_out)
		else $error("reference pulse longer than one cycle");

	load_seen_c: cover property ($rose(latch_load_strobe));
	tx_switch_c: cover property (!tx_switched_filter_oe_n);
	rx_switch_c: cover property (!rx_switched_filter_oe_n);
	rx_pump_c:   cover property (!rx_pump_oe_n);
endmodule

// >>> dual_pll_serial_divider_control_bench.sv
`timescale 1ns/1ps
module dual_pll_serial_divider_control_bench;
	import pll_pkg::*;
	logic        mclk, rst_n, xtal, vco, wr, rd;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, v;
	logic        ref_mon, div_mon, tx_po, tx_poe_n, rx_po, rx_poe_n;
	logic        tx_so, tx_soe_n, rx_so, rx_soe_n;
	logic        xtal_run, vco_run, tx_sup, rx_sup, tx_lock, rx_lock;
	logic [22:0] w1;
	int          n_mismatch, check_count, p;

	synth_link_if link ();
	serial_host serial_host_i (.mclk(mclk), .rst_n(rst_n), .link(link),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	synth_device synth_device_i (.mclk(mclk), .rst_n(rst_n), .link(link),
		.crystal_clock_in(xtal), .tx_vco_input(vco), .rx_vco_input(vco),
		.tx_supply_on(tx_sup), .rx_supply_on(rx_sup),
		.reference_monitor_out(ref_mon), .divider_monitor_out(div_mon),
		.tx_lock_flag(tx_lock), .rx_lock_flag(rx_lock),
		.tx_pump_out(tx_po), .tx_pump_oe_n(tx_poe_n),
		.rx_pump_out(rx_po), .rx_pump_oe_n(rx_poe_n),
		.tx_switched_filter_out(tx_so),
		.tx_switched_filter_oe_n(tx_soe_n),
		.rx_switched_filter_out(rx_so), .rx_switched_filter_oe_n(rx_soe_n));
	synth_link_asserts synth_link_asserts_i (.mclk(mclk), .rst_n(rst_n),
		.ser_data(link.ser_data), .shift_clk(link.shift_clk),
		.latch_load_strobe(link.latch_load_strobe),
		.reference_monitor_out(ref_mon), .tx_pump_out(tx_po),
		.tx_pump_oe_n(tx_poe_n), .rx_pump_out(rx_po),
		.rx_pump_oe_n(rx_poe_n),
		.tx_switched_filter_out(tx_so),
		.tx_switched_filter_oe_n(tx_soe_n),
		.rx_switched_filter_out(rx_so),
		.rx_switched_filter_oe_n(rx_soe_n));

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// crystal and vco rise every second cycle, so periods are 2x counts;
	// a stopped source parks low so no false rise follows a restart
	always @(posedge mclk) begin
		xtal <= xtal_run & ~xtal;
		vco  <= vco_run & ~vco;
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic print_verdict();
		if (n_mismatch == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk);
		wr    <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge mclk);
		rd   <= 1'b0;
		#1 d = rdata;
	endtask

	// write a word, then poll status until the sticky done bit shows
	task automatic load(input logic [22:0] w);
		int i;
		wr_reg(REG_WORD, {9'h000, w});
		v = 32'h0000_0000;
		for (i = 0; i < 400 && v[STAT_DONE] !== 1'b1; i++)
			rd_reg(REG_STAT, v);
		if (v[STAT_DONE] !== 1'b1) begin
			n_mismatch++;
			print_verdict();
		end
	endtask

	// cycles between two pulses; called twice since the first may be short
	task automatic period(input bit use_ref, output int n);
		int i;
		for (i = 0; i < 8000 && (use_ref ? ref_mon : div_mon) !== 1'b1; i++)
			@(negedge mclk);
		@(negedge mclk);
		for (n = 1; n < 8000 && (use_ref ? ref_mon : div_mon) !== 1'b1; n++)
			@(negedge mclk);
		if (i >= 8000 || n >= 8000) begin
			n_mismatch++;
			print_verdict();
		end
	endtask

	function automatic logic [22:0] mk(input logic [10:0] n,
		input logic [6:0] a, input logic pol, mon, refs, sel);
		return {n, a, pol, mon, refs, 1'b0, sel};
	endfunction

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		n_mismatch  = 0;
		check_count = 0;
		rst_n = 1'b0;
		xtal  = 1'b0;
		vco   = 1'b0;
		wr    = 1'b0;
		rd    = 1'b0;
		addr  = 8'h00;
		wdata = 32'h0000_0000;
		xtal_run = 1'b1;
		vco_run  = 1'b1;
		tx_sup   = 1'b1;
		rx_sup   = 1'b1;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		rd_reg(8'h08, v);
		chk("unmapped read", v, 32'h0000_0000);
		rd_reg(REG_STAT, v);
		chk("idle busy", {31'h0, v[STAT_BUSY]}, 32'h0000_0000);
		w1 = mk(11'h010, 7'h03, 1'b1, 1'b1, 1'b1, 1'b1);
		wr_reg(REG_WORD, {9'h000, w1});
		load(mk(11'h7FF, 7'h7F, 1'b0, 1'b0, 1'b0, 1'b0));
		rd_reg(REG_WORD, v);
		chk("word readback", v, {9'h000, w1});
		period(1'b1, p);
		period(1'b1, p);
		chk("ref period 512", 32'(p), 32'h0000_0400);
		period(1'b0, p);
		period(1'b0, p);
		chk("tx divided period", 32'(p), 32'h0000_0806);
		load(mk(11'h011, 7'h00, 1'b0, 1'b1, 1'b0, 1'b0));
		period(1'b0, p);
		period(1'b0, p);
		chk("tx kept after rx load", 32'(p), 32'h0000_0806);
		period(1'b1, p);
		period(1'b1, p);
		chk("ref period 1024", 32'(p), 32'h0000_0800);
		load(mk(11'h011, 7'h00, 1'b0, 1'b0, 1'b0, 1'b0));
		period(1'b0, p);
		period(1'b0, p);
		chk("rx divided period", 32'(p), 32'h0000_0880);
		// mid-run reset with both sources parked, so the reference and
		// divider counters restart together and the phase can be set
		@(posedge mclk);
		rst_n    <= 1'b0;
		xtal_run <= 1'b0;
		vco_run  <= 1'b0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		@(negedge mclk);
		chk("reset lock", {30'h0, tx_lock, rx_lock}, 32'h0);
		load(mk(11'h010, 7'h00, 1'b1, 1'b1, 1'b0, 1'b1));
		// 65 vco rises alone: the divider reloads at rise 64 and then
		// runs one rise ahead of the reference, a two-cycle phase error
		vco_run <= 1'b1;
		repeat (130) @(posedge mclk);
		xtal_run <= 1'b1;
		for (p = 0; p < 12000 && tx_lock !== 1'b1; p++)
			@(negedge mclk);
		chk("tx lock gained", {31'h0, tx_lock}, 32'h1);
		if (tx_lock !== 1'b1)
			print_verdict();
		chk("rx unlocked", {31'h0, rx_lock}, 32'h0);
		for (p = 0; p < 2500 && tx_poe_n !== 1'b0; p++)
			@(negedge mclk);
		chk("pump lo", {30'h0, tx_poe_n, tx_po}, 32'h0);
		// stall the vco 100 rises: the reference now leads by 198 cycles
		vco_run <= 1'b0;
		repeat (200) @(negedge mclk);
		vco_run <= 1'b1;
		for (p = 0; p < 3000 && tx_lock !== 1'b0; p++)
			@(negedge mclk);
		chk("pump hi", {30'h0, tx_poe_n, tx_po}, 32'h1);
		chk("tx lock lost", {31'h0, tx_lock}, 32'h0);
		@(posedge mclk);
		tx_sup <= 1'b0;
		repeat (4) @(posedge mclk);
		tx_sup <= 1'b1;
		period(1'b0, p);
		period(1'b0, p);
		chk("tx cleared by supply", 32'(p), 32'h0000_0080);
		load(mk(11'h010, 7'h00, 1'b0, 1'b0, 1'b1, 1'b0));
		@(posedge mclk);
		rx_sup <= 1'b0;
		repeat (4) @(posedge mclk);
		rx_sup <= 1'b1;
		period(1'b1, p);
		period(1'b1, p);
		chk("ref cleared by supply", 32'(p), 32'h0000_0800);
		period(1'b0, p);
		period(1'b0, p);
		chk("rx cleared by supply", 32'(p), 32'h0000_0080);
		print_verdict();
	end
endmodule
